// ===== logic/pcfg_pkg.sv
// Constants for the 1394 host controller configuration header
package pcfg_pkg;
    // Printed byte offsets
    localparam logic [7:0] OFF_ID = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h06;
    localparam logic [7:0] OFF_CLASS = 8'h08;
    localparam logic [7:0] OFF_LAT_CLS = 8'h0c;
    localparam logic [7:0] OFF_HDR = 8'h0e;
    localparam logic [7:0] OFF_BAR0 = 8'h10;
    localparam logic [7:0] OFF_BAR1 = 8'h14;
    localparam logic [5:0] IDX_ID = OFF_ID[7:2];
    localparam logic [5:0] IDX_CMD = OFF_CMD[7:2];
    localparam logic [5:0] IDX_CLASS = OFF_CLASS[7:2];
    localparam logic [5:0] IDX_LAT = OFF_LAT_CLS[7:2];
    localparam logic [5:0] IDX_BAR0 = OFF_BAR0[7:2];
    localparam logic [5:0] IDX_BAR1 = OFF_BAR1[7:2];
    // Status word bit positions
    localparam int ST_PARITY = 15;
    localparam int ST_SYS_FAULT = 14;
    localparam int ST_MSTR_ABORT = 13;
    localparam int ST_TABORT_RCV = 12;
    localparam int ST_TABORT_SENT = 11;
    localparam int ST_MDATA_PAR = 8;
    localparam logic [15:0] STATUS_RESET = 16'h0230;
    localparam logic [15:0] STATUS_W1C_MASK = 16'hf900;
    localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
    localparam logic BACK_TO_BACK_CAP = 1'h0;
    localparam logic USER_FEATURE = 1'h0;
    localparam logic FAST_CLOCK_CAP = 1'h1;
    localparam logic CAP_CHAIN = 1'h1;
    localparam logic [2:0] STATUS_RSVD = 3'h0;
    // Command register bits kept here
    localparam int CMD_PARITY_RESP = 6;
    localparam int CMD_SYS_FAULT_EN = 8;
    localparam int CMD_INT_DISABLE = 10;
    localparam logic [31:0] CMD_WR_MASK = 32'h0000_0540;
    // Fixed codes
    localparam logic [7:0] PRIMARY_CATEGORY = 8'h0c;
    localparam logic [7:0] SUB_CATEGORY = 8'h00;
    localparam logic [7:0] PROGRAMMING_MODEL = 8'h10;
    localparam logic [7:0] HEADER_KIND = 8'h00;
    localparam logic [7:0] SELF_TEST_CODE = 8'h00;
    localparam logic [31:0] LAT_WR_MASK = 32'h0000_ffff;
    localparam logic [31:0] BAR0_WR_MASK = 32'hffff_f800;
    localparam logic [31:0] BAR1_WR_MASK = 32'hffff_c000;
    // Bus commands and type-0 address code
    localparam logic [3:0] CMD_CFG_READ = 4'ha;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;
    localparam logic [1:0] CFG_TYPE0 = 2'h0;
    localparam int SYNC_W = 42;
endpackage

// ===== logic/pcfg_lat_if.sv
// Bundle between the configuration target and the latency timer
`timescale 1ns/1ps
interface pcfg_lat_if;
    logic tick;
    logic start;
    logic done;
    logic gnt_n;
    logic [7:0] limit;
    logic expired;
    logic end_req;
    modport ctrl (output tick, output start, output done, output gnt_n, output limit,
                  input expired, input end_req);
    modport timer (input tick, input start, input done, input gnt_n, input limit,
                   output expired, output end_req);
endinterface

// ===== logic/pcfg_sync.sv
// Two-stage synchroniser for the bus pins
`timescale 1ns/1ps
module pcfg_sync #(
    parameter int W = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                meta_q[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end
endmodule

// ===== logic/pcfg_lat.sv
// Initiator latency timer
`timescale 1ns/1ps
module pcfg_lat (
    input wire logic clk_sys,
    input wire logic resetn,
    pcfg_lat_if.timer lat
);
    import pcfg_pkg::*;
    logic run_q;
    logic [7:0] count_q;
    wire logic at_limit = count_q >= lat.limit;

    // Count from zero once the initiator frame starts
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            run_q <= 1'b0;
            count_q <= 8'h00;
        end else if (lat.start) begin
            run_q <= 1'b1;
            count_q <= 8'h00;
        end else if (lat.done) begin
            run_q <= 1'b0;
        end else if (run_q && lat.tick && !at_limit) begin
            count_q <= count_q + 8'h01;
        end
    end

    assign lat.expired = run_q && at_limit;
    assign lat.end_req = lat.expired && lat.gnt_n;

    chk_lat_end_grant: assert property (@(posedge clk_sys) disable iff (!resetn)
        lat.end_req |-> run_q && count_q >= lat.limit && lat.gnt_n)
        else $error("latency end request without expiry and lost grant");
    chk_lat_restart: assert property (@(posedge clk_sys) disable iff (!resetn)
        lat.start |=> count_q == 8'h00 && run_q)
        else $error("latency timer did not restart from zero");
endmodule

// ===== logic/pcfg_top.sv
// Configuration header target of the 1394 host controller function
`timescale 1ns/1ps
module pcfg_top #(
    parameter logic [15:0] VENDOR_CODE = 16'h1234, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h5678, // arbitrary value
    parameter logic [7:0] SILICON_REVISION = 8'h5a // arbitrary value
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic pci_clk,
    input wire logic frame_n,
    input wire logic irdy_n,
    input wire logic idsel,
    input wire logic gnt_n,
    input wire logic [3:0] cbe_n,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe_n,
    output logic par_out,
    output logic par_oe_n,
    output logic devsel_out,
    output logic devsel_oe_n,
    output logic trdy_out,
    output logic trdy_oe_n,
    output logic stop_out,
    output logic stop_oe_n,
    input wire logic perr_n_in,
    output logic perr_out,
    output logic perr_oe_n,
    output logic serr_out,
    output logic serr_oe_n,
    output logic inta_out,
    output logic inta_oe_n,
    input wire logic addr_parity_evt,
    input wire logic data_parity_evt,
    input wire logic master_abort_evt,
    input wire logic target_abort_rcv_evt,
    input wire logic target_abort_sig_evt,
    input wire logic master_data_phase,
    input wire logic int_condition,
    input wire logic init_frame_start,
    input wire logic init_done,
    output logic init_end_request,
    output logic [7:0] line_size_setting,
    output logic [20:0] host_ctrl_window_pointer,
    output logic [17:0] extension_window_pointer
);
    import pcfg_pkg::*;

    typedef enum {S_IDLE, S_DATA, S_TURN} pcfg_state_t;

    pcfg_state_t state_q;
    logic [SYNC_W-1:0] sync_v;
    logic clk_prev_q;
    logic [5:0] idx_q;
    logic wr_q;
    logic [15:0] st_q;
    logic [31:0] cmd_q;
    logic [31:0] lat_q;
    logic [31:0] bar0_q;
    logic [31:0] bar1_q;
    logic int_q;
    logic serr_q;
    logic perr_q;
    pcfg_lat_if lat_bus ();

    pcfg_sync #(.W(SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in({pci_clk, frame_n, irdy_n, idsel, gnt_n, perr_n_in, cbe_n, ad_in}),
        .sync_out(sync_v)
    );

    pcfg_lat u_lat (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .lat(lat_bus.timer)
    );

    // Synchronised pins
    wire logic clk_s = sync_v[41];
    wire logic frame_n_s = sync_v[40];
    wire logic irdy_n_s = sync_v[39];
    wire logic idsel_s = sync_v[38];
    wire logic gnt_n_s = sync_v[37];
    wire logic perr_n_s = sync_v[36];
    wire logic [3:0] cbe_n_s = sync_v[35:32];
    wire logic [31:0] ad_s = sync_v[31:0];
    // Act mid-period, where the host holds the bus stable
    wire logic pci_fall = clk_prev_q && !clk_s;

    wire logic cfg_hit = pci_fall && state_q == S_IDLE && !frame_n_s && idsel_s
        && (cbe_n_s == CMD_CFG_READ || cbe_n_s == CMD_CFG_WRITE) && ad_s[1:0] == CFG_TYPE0;
    wire logic xfer = pci_fall && state_q == S_DATA && !irdy_n_s;
    wire logic wr_fire = xfer && wr_q;
    wire logic [31:0] lane = {{8{!cbe_n_s[3]}}, {8{!cbe_n_s[2]}}, {8{!cbe_n_s[1]}},
                              {8{!cbe_n_s[0]}}};

    // Status word assembly
    wire logic [15:0] status_word = {st_q[15:11], DEVSEL_MEDIUM, st_q[ST_MDATA_PAR],
        BACK_TO_BACK_CAP, USER_FEATURE, FAST_CLOCK_CAP, CAP_CHAIN,
        int_q, STATUS_RSVD};
    wire logic [31:0] read_mux =
        (ad_s[7:2] == IDX_ID) ? {DEVICE_CODE, VENDOR_CODE} :
        (ad_s[7:2] == IDX_CMD) ? {status_word, cmd_q[15:0]} :
        (ad_s[7:2] == IDX_CLASS) ? {PRIMARY_CATEGORY, SUB_CATEGORY, PROGRAMMING_MODEL,
                                    SILICON_REVISION} :
        (ad_s[7:2] == IDX_LAT) ? {SELF_TEST_CODE, HEADER_KIND, lat_q[15:0]} :
        (ad_s[7:2] == IDX_BAR0) ? bar0_q :
        (ad_s[7:2] == IDX_BAR1) ? bar1_q : 32'h0000_0000;

    // Sticky flags: hardware set wins over a software clear
    wire logic sys_fault_go = addr_parity_evt && cmd_q[CMD_SYS_FAULT_EN];
    wire logic mdata_par_go = pci_fall && master_data_phase && !perr_n_s
        && cmd_q[CMD_PARITY_RESP];
    wire logic [15:0] st_set = {addr_parity_evt || data_parity_evt, sys_fault_go,
        master_abort_evt, target_abort_rcv_evt, target_abort_sig_evt,
        2'h0, mdata_par_go, 8'h00};
    wire logic [15:0] st_clr = (wr_fire && idx_q == IDX_CMD) ?
        ad_s[31:16] & lane[31:16] & STATUS_W1C_MASK : 16'h0000;
    wire logic [15:0] st_d = (st_q & ~st_clr) | st_set;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] en);
        return (old & ~en) | (nw & en);
    endfunction

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clk_prev_q <= 1'b0;
            st_q <= STATUS_RESET & STATUS_W1C_MASK;
            int_q <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
            st_q <= st_d;
            int_q <= int_condition;
        end
    end

    // Writable registers with byte enables and per-register write masks
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmd_q <= 32'h0000_0000;
            lat_q <= 32'h0000_0000;
            bar0_q <= 32'h0000_0000;
            bar1_q <= 32'h0000_0000;
        end else if (wr_fire) begin
            if (idx_q == IDX_CMD) cmd_q <= merge(cmd_q, ad_s, lane & CMD_WR_MASK);
            if (idx_q == IDX_LAT) lat_q <= merge(lat_q, ad_s, lane & LAT_WR_MASK);
            if (idx_q == IDX_BAR0) bar0_q <= merge(bar0_q, ad_s, lane & BAR0_WR_MASK);
            if (idx_q == IDX_BAR1) bar1_q <= merge(bar1_q, ad_s, lane & BAR1_WR_MASK);
        end
    end

    // Configuration target handshake
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= S_IDLE;
            idx_q <= 6'h00;
            wr_q <= 1'b0;
            ad_out <= 32'h0000_0000;
            ad_oe_n <= 1'b1;
            par_out <= 1'b0;
            par_oe_n <= 1'b1;
            devsel_out <= 1'b1;
            devsel_oe_n <= 1'b1;
            trdy_out <= 1'b1;
            trdy_oe_n <= 1'b1;
        end else if (pci_fall) begin
            unique case (state_q)
                S_IDLE: begin
                    par_oe_n <= 1'b1;
                    devsel_oe_n <= 1'b1;
                    trdy_oe_n <= 1'b1;
                    if (cfg_hit) begin
                        state_q <= S_DATA;
                        idx_q <= ad_s[7:2];
                        wr_q <= cbe_n_s == CMD_CFG_WRITE;
                        ad_out <= read_mux;
                        ad_oe_n <= cbe_n_s == CMD_CFG_WRITE;
                        devsel_out <= 1'b0;
                        devsel_oe_n <= 1'b0;
                        trdy_out <= 1'b0;
                        trdy_oe_n <= 1'b0;
                    end
                end
                S_DATA: begin
                    if (!irdy_n_s) begin
                        state_q <= S_TURN;
                        ad_oe_n <= 1'b1;
                        par_out <= ^{ad_out, cbe_n_s};
                        par_oe_n <= wr_q;
                        devsel_out <= 1'b1;
                        trdy_out <= 1'b1;
                    end
                end
                S_TURN: begin
                    state_q <= S_IDLE;
                    par_oe_n <= 1'b1;
                    devsel_oe_n <= 1'b1;
                    trdy_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Error lines held until the next falling bus clock edge
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serr_q <= 1'b0;
            perr_q <= 1'b0;
        end else begin
            if (sys_fault_go) serr_q <= 1'b1;
            else if (pci_fall) serr_q <= 1'b0;
            if (data_parity_evt && cmd_q[CMD_PARITY_RESP]) perr_q <= 1'b1;
            else if (pci_fall) perr_q <= 1'b0;
        end
    end

    assign stop_out = 1'b1;
    assign stop_oe_n = 1'b1;
    assign serr_out = 1'b0;
    assign serr_oe_n = !serr_q;
    assign perr_out = 1'b0;
    assign perr_oe_n = !perr_q;
    assign inta_out = 1'b0;
    assign inta_oe_n = !(int_q && !cmd_q[CMD_INT_DISABLE]);

    assign lat_bus.tick = pci_fall;
    assign lat_bus.start = init_frame_start;
    assign lat_bus.done = init_done;
    assign lat_bus.gnt_n = gnt_n_s;
    assign lat_bus.limit = lat_q[15:8];
    assign init_end_request = lat_bus.end_req;
    assign line_size_setting = lat_q[7:0];
    assign host_ctrl_window_pointer = bar0_q[31:11];
    assign extension_window_pointer = bar1_q[31:14];

    // Status flags, fixed read values and pin gating
    chk_parity_sets: assert property (@(posedge clk_sys) disable iff (!resetn)
        (addr_parity_evt || data_parity_evt) |=> st_q[ST_PARITY])
        else $error("parity flag not set after parity error");
    chk_sys_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(serr_q) |-> st_q[ST_SYS_FAULT] && $past(cmd_q[CMD_SYS_FAULT_EN]))
        else $error("system fault drive and flag disagree");
    chk_master_abort: assert property (@(posedge clk_sys) disable iff (!resetn)
        master_abort_evt |=> st_q[ST_MSTR_ABORT])
        else $error("master abort flag not set");
    chk_tabort_rcv: assert property (@(posedge clk_sys) disable iff (!resetn)
        target_abort_rcv_evt |=> st_q[ST_TABORT_RCV])
        else $error("received target abort flag not set");
    chk_abort_signalled: assert property (@(posedge clk_sys) disable iff (!resetn)
        target_abort_sig_evt ##1 !target_abort_sig_evt [*2] |-> st_q[ST_TABORT_SENT]
            || $past(wr_fire))
        else $error("signalled target abort flag lost");
    chk_status_read: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg_hit && ad_s[7:2] == IDX_CMD && cbe_n_s == CMD_CFG_READ |=>
            ad_out[26:25] == DEVSEL_MEDIUM && ad_out[23:20] == 4'h3 && ad_out[18:16] == 3'h0)
        else $error("status fixed bits read wrong");
    chk_mdata_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(st_q[ST_MDATA_PAR]) |-> $past(cmd_q[CMD_PARITY_RESP]) && $past(!perr_n_s))
        else $error("master data parity flag set without cause");
    chk_inta_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        !inta_oe_n |-> int_q && !cmd_q[CMD_INT_DISABLE] && status_word[3])
        else $error("interrupt driven while masked or idle");
    chk_bar_low_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        wr_fire ##1 1'b1 |-> bar0_q[10:0] == 11'h000 && bar1_q[13:0] == 14'h0000)
        else $error("window base low bits not zero");
    chk_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
        master_abort_evt && st_clr[ST_MSTR_ABORT] |=> st_q[ST_MSTR_ABORT])
        else $error("clear beat a simultaneous set");
    chk_clear_one: assert property (@(posedge clk_sys) disable iff (!resetn)
        st_clr[ST_MSTR_ABORT] && !master_abort_evt |=> !st_q[ST_MSTR_ABORT])
        else $error("write one did not clear flag");
    chk_perr_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(perr_oe_n) |-> $past(cmd_q[CMD_PARITY_RESP]))
        else $error("parity error driven while response disabled");
endmodule

// ===== bench/pcfg_host.sv
// Host model issuing single-phase configuration cycles on the bus pins
`timescale 1ns/1ps
module pcfg_host (
    input wire logic clk_sys,
    output logic pci_clk,
    output logic frame_n,
    output logic irdy_n,
    output logic idsel,
    output logic [3:0] cbe_n,
    output logic [31:0] ad_in,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic devsel_out,
    input wire logic devsel_oe_n,
    input wire logic trdy_out,
    input wire logic trdy_oe_n
);
    import pcfg_pkg::*;
    logic [31:0] host_ad = 32'h0;
    logic [31:0] last_ad = 32'h0;
    logic host_oe = 1'b0;
    logic hit_s;
    logic [31:0] rd_s;
    // Pulled-up target lines; a floating data bus shows the inverse of its last value
    wire devsel_w = devsel_oe_n | devsel_out;
    wire trdy_w = trdy_oe_n | trdy_out;
    assign ad_in = !ad_oe_n ? ad_out : (host_oe ? host_ad : ~last_ad);
    always @(posedge clk_sys) begin
        if (!ad_oe_n || host_oe) begin
            last_ad <= ad_in;
        end
    end
    initial begin
        pci_clk = 1'b0;
        frame_n = 1'b1;
        irdy_n = 1'b1;
        idsel = 1'b0;
        cbe_n = 4'hf;
    end
    // Bus clock runs only while a cycle or a timed burst is under way
    task automatic rise();
        @(posedge clk_sys);
        #2;
        pci_clk = 1'b1;
    endtask
    task automatic fall();
        repeat (4) @(posedge clk_sys);
        #2;
        hit_s = !devsel_w && !trdy_w;
        rd_s = ad_in;
        pci_clk = 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic run_clk(input int n);
        repeat (n) begin
            rise();
            fall();
        end
    endtask
    task automatic cfg(input logic [3:0] cmd, input logic [7:0] addr, input logic [3:0] be_n,
                       input logic [31:0] wd, output logic [31:0] rd, output logic hit);
        rise();
        frame_n = 1'b0;
        idsel = 1'b1;
        cbe_n = cmd;
        host_ad = {24'h0, addr};
        host_oe = 1'b1;
        fall();
        rise();
        frame_n = 1'b1;
        irdy_n = 1'b0;
        cbe_n = be_n;
        host_ad = wd;
        host_oe = (cmd == CMD_CFG_WRITE);
        fall();
        hit = hit_s;
        rd = rd_s;
        rise();
        irdy_n = 1'b1;
        idsel = 1'b0;
        cbe_n = 4'hf;
        host_oe = 1'b0;
        fall();
        run_clk(1);
    endtask
endmodule

// ===== bench/pcfg_top_bench.sv
// Self-checking bench for the configuration header target
`timescale 1ns/1ps
module pcfg_top_bench;
    import pcfg_pkg::*;
    localparam logic [7:0] REV = 8'h3c; // arbitrary value
    localparam int EB[5] = '{15, 15, 13, 12, 11};
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic gnt_n = 1'b0;
    logic int_condition = 1'b0;
    logic master_data_phase = 1'b0;
    logic agent_perr_n = 1'b1;
    logic [6:0] pls = 7'h0;
    logic pci_clk, frame_n, irdy_n, idsel, ad_oe_n, devsel_out, devsel_oe_n, trdy_out;
    logic trdy_oe_n, perr_oe_n, serr_oe_n, inta_oe_n, init_end_request, perr_n_in;
    logic [3:0] cbe_n;
    logic [31:0] ad_in, ad_out, r;
    logic [7:0] line_size_setting;
    logic [20:0] host_ctrl_window_pointer;
    logic [17:0] extension_window_pointer;
    logic h;
    logic par_out;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    assign perr_n_in = agent_perr_n & perr_oe_n;
    always #10 clk_sys = ~clk_sys;
    pcfg_top #(.SILICON_REVISION(REV)) pcfg_top_i (
        .clk_sys, .resetn, .pci_clk, .frame_n, .irdy_n, .idsel, .gnt_n, .cbe_n, .ad_in,
        .ad_out, .ad_oe_n, .par_out, .par_oe_n(), .devsel_out, .devsel_oe_n, .trdy_out,
        .trdy_oe_n, .stop_out(), .stop_oe_n(), .perr_n_in, .perr_out(), .perr_oe_n,
        .serr_out(), .serr_oe_n, .inta_out(), .inta_oe_n, .addr_parity_evt(pls[0]),
        .data_parity_evt(pls[1]), .master_abort_evt(pls[2]), .target_abort_rcv_evt(pls[3]),
        .target_abort_sig_evt(pls[4]), .master_data_phase, .int_condition,
        .init_frame_start(pls[5]), .init_done(pls[6]), .init_end_request, .line_size_setting,
        .host_ctrl_window_pointer, .extension_window_pointer);
    pcfg_host pcfg_host_i (.clk_sys, .pci_clk, .frame_n, .irdy_n, .idsel, .cbe_n, .ad_in,
        .ad_out, .ad_oe_n, .devsel_out, .devsel_oe_n, .trdy_out, .trdy_oe_n);
    task automatic end_sim();
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [3:0] be_n, input logic [31:0] d);
        pcfg_host_i.cfg(CMD_CFG_WRITE, {idx, CFG_TYPE0}, be_n, d, r, h);
        cmp_bit(h, 1'b1);
    endtask
    task automatic chk(input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
        pcfg_host_i.cfg(CMD_CFG_READ, {idx, CFG_TYPE0}, 4'h0, 32'h0, r, h);
        cmp_bit(h, 1'b1);
        cmp_reg(r & m, e);
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        #2;
        pls[k] = 1'b1;
        @(posedge clk_sys);
        #2;
        pls[k] = 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        #2;
        resetn = 1'b0;
        repeat (3) @(posedge clk_sys);
        #2;
        resetn = 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic perr_try(input logic m, input logic [31:0] e);
        @(posedge clk_sys);
        #2;
        master_data_phase = m;
        agent_perr_n = 1'b0;
        pcfg_host_i.run_clk(1);
        #2;
        agent_perr_n = 1'b1;
        master_data_phase = 1'b0;
        chk(IDX_CMD, 32'h0100_0000, e);
    endtask
    initial begin
        do_reset();
        chk(IDX_CMD, 32'hffff_ffff, 32'h0230_0000);
        chk(IDX_CLASS, 32'hffff_ffff, {24'h0c_0010, REV});
        chk(IDX_LAT, 32'hffff_ffff, 32'h0);
        chk(IDX_BAR0, 32'hffff_ffff, 32'h0);
        chk(IDX_BAR1, 32'hffff_ffff, 32'h0);
        wr(IDX_CLASS, 4'h0, 32'hffff_ffff);
        chk(IDX_CLASS, 32'hffff_ffff, {24'h0c_0010, REV});
        cmp_bit(par_out, ^{r, 4'h0});
        wr(IDX_LAT, 4'h0, 32'hffff_ffff);
        chk(IDX_LAT, 32'hffff_ffff, 32'h0000_ffff);
        cmp_reg({24'h0, line_size_setting}, 32'hff);
        wr(IDX_BAR0, 4'h0, 32'hffff_ffff);
        chk(IDX_BAR0, 32'hffff_ffff, 32'hffff_f800);
        cmp_reg({11'h0, host_ctrl_window_pointer}, 32'h1f_ffff);
        wr(IDX_BAR1, 4'h0, 32'hffff_ffff);
        chk(IDX_BAR1, 32'hffff_ffff, 32'hffff_c000);
        cmp_reg({14'h0, extension_window_pointer}, 32'h3_ffff);
        wr(IDX_LAT, 4'he, 32'h0000_1234);
        chk(IDX_LAT, 32'hffff_ffff, 32'h0000_ff34);
        wr(6'h0a, 4'h0, 32'hffff_ffff);
        chk(6'h0a, 32'hffff_ffff, 32'h0);
        pcfg_host_i.cfg(CMD_CFG_WRITE, {IDX_BAR0, 2'h1}, 4'h0, 32'h0, r, h);
        cmp_bit(h, 1'b0);
        pcfg_host_i.cfg(4'h6, {IDX_BAR0, CFG_TYPE0}, 4'h0, 32'h0, r, h);
        cmp_bit(h, 1'b0);
        chk(IDX_BAR0, 32'hffff_ffff, 32'hffff_f800);
        for (int k = 0; k < 5; k++) begin
            pulse(k);
            wait_clk(1);
            cmp_bit(serr_oe_n, 1'b1);
            cmp_bit(perr_oe_n, 1'b1);
            chk(IDX_CMD, 32'hffff_0000, (32'h0230 | (32'h1 << EB[k])) << 16);
            wr(IDX_CMD, 4'h3, 32'h0007_0000);
            chk(IDX_CMD, 32'hffff_0000, (32'h0230 | (32'h1 << EB[k])) << 16);
            wr(IDX_CMD, 4'h3, 32'hffff_0000);
            chk(IDX_CMD, 32'hffff_0000, 32'h0230_0000);
        end
        // Master abort lands in the same cycle as its clear
        fork
            wr(IDX_CMD, 4'h3, 32'h2000_0000);
            begin
                repeat (14) @(posedge clk_sys);
                pulse(2);
            end
        join
        chk(IDX_CMD, 32'hffff_0000, 32'h2230_0000);
        wr(IDX_CMD, 4'h3, 32'h2000_0000);
        chk(IDX_CMD, 32'hffff_0000, 32'h0230_0000);
        perr_try(1'b1, 32'h0);
        wr(IDX_CMD, 4'hc, 32'h0000_0140);
        chk(IDX_CMD, 32'h0000_ffff, 32'h0000_0140);
        perr_try(1'b0, 32'h0);
        perr_try(1'b1, 32'h0100_0000);
        wr(IDX_CMD, 4'h3, 32'hffff_0000);
        pulse(0);
        wait_clk(1);
        cmp_bit(serr_oe_n, 1'b0);
        pulse(1);
        wait_clk(1);
        cmp_bit(perr_oe_n, 1'b0);
        chk(IDX_CMD, 32'hffff_0000, 32'hc230_0000);
        wr(IDX_CMD, 4'h0, 32'hffff_0000);
        #2 int_condition = 1'b1;
        chk(IDX_CMD, 32'h0008_0000, 32'h0008_0000);
        cmp_bit(inta_oe_n, 1'b0);
        wr(IDX_CMD, 4'hc, 32'h0000_0400);
        chk(IDX_CMD, 32'h0008_0000, 32'h0008_0000);
        cmp_bit(inta_oe_n, 1'b1);
        #2 int_condition = 1'b0;
        wr(IDX_CMD, 4'hc, 32'h0);
        chk(IDX_CMD, 32'h0008_0000, 32'h0);
        cmp_bit(inta_oe_n, 1'b1);
        wr(IDX_LAT, 4'hc, 32'h0000_0310);
        #2 gnt_n = 1'b1;
        pulse(5);
        pcfg_host_i.run_clk(2);
        wait_clk(4);
        cmp_bit(init_end_request, 1'b0);
        pcfg_host_i.run_clk(1);
        wait_clk(4);
        cmp_bit(init_end_request, 1'b1);
        pulse(6);
        wait_clk(2);
        cmp_bit(init_end_request, 1'b0);
        gnt_n = 1'b0;
        pulse(5);
        pcfg_host_i.run_clk(4);
        wait_clk(4);
        cmp_bit(init_end_request, 1'b0);
        gnt_n = 1'b1;
        wait_clk(5);
        cmp_bit(init_end_request, 1'b1);
        pulse(6);
        do_reset();
        chk(IDX_CMD, 32'hffff_ffff, 32'h0230_0000);
        chk(IDX_LAT, 32'hffff_ffff, 32'h0);
        chk(IDX_BAR0, 32'hffff_ffff, 32'h0);
        cmp_bit(init_end_request, 1'b0);
        end_sim();
    end
endmodule
